/* design/ssdp_pkg.sv */
// Purpose: shared constants and types of the serial data path
// Assumes: 16-bit register port, byte offsets below
// Notes: none
package ssdp_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] SSDP_CTRL_OFS = 4'h0;
  localparam logic [3:0] SSDP_EXT_OFS = 4'h4;
  localparam logic [3:0] SSDP_STAT_OFS = 4'h8;
  localparam logic [3:0] SSDP_DATA_OFS = 4'hC;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SSDP_FORCE_BIT = 7;
  localparam int SSDP_CLR_OVR_BIT = 8;
  localparam int SSDP_ST_FULL = 0;
  localparam int SSDP_ST_EMPTY = 1;
  localparam int SSDP_ST_OVR = 2;
  localparam int SSDP_ST_IDLE = 3;
  // ----------------------------------------------------------------
  // reset values and default half period
  // ----------------------------------------------------------------
  localparam logic [7:0] SSDP_CTRL_RST = 8'h00;
  localparam logic [4:0] SSDP_EXT_RST = 5'h00;
  localparam logic [8:0] SSDP_TX_RST = 9'h1FF;
  localparam logic [8:0] SSDP_RX_RST = 9'h000;
  localparam logic [3:0] SSDP_HALF_DIV = 4'h4;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rx_thresh;
    logic rx_fifo_en;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic master;
    logic rx_enable;
    logic tx_enable;
  } ssdp_ctrl_t;
  typedef struct packed {
    logic [1:0] wait_sel;
    logic [2:0] length_sel;
  } ssdp_ext_t;
  typedef enum logic [1:0] {st_idle, st_shift, st_wait} ssdp_state_t;
endpackage

/* design/ssdp_core.sv */
// Purpose: framing and data path of a clock-synchronous serial port
// Assumes: serial clock idles high, data out on falling, sampled on rising
// Notes: lsb first; transmit buffer has no fifo
`timescale 1ns/10ps
`default_nettype none
module ssdp_core
  import ssdp_pkg::*;
#(
  parameter int HALF_DIV = SSDP_HALF_DIV,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic serial_input_pin,
  output logic serial_out_pin,
  output logic rx_irq,
  output logic tx_irq
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(FIFO_DEPTH);
  localparam logic [3:0] HDIV_C = 4'(HALF_DIV);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ssdp_ctrl_t ctrl_q;
  ssdp_ext_t ext_q;
  ssdp_state_t state_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q, sin_s1_q, sin_s2_q;
  logic sck_q, sout_q;
  logic [3:0] div_q, bit_q;
  logic [7:0] wait_q;
  logic [8:0] tx_data_q, tx_sh_q, rx_sh_q, rx_data_q;
  logic tx_empty_q, rx_full_q, ovr_q;
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [PW:0] cnt_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && reg_addr == SSDP_CTRL_OFS;
  wire wr_ext = reg_wr && reg_addr == SSDP_EXT_OFS;
  wire wr_data = reg_wr && reg_addr == SSDP_DATA_OFS;
  wire rd_data = reg_rd && reg_addr == SSDP_DATA_OFS;
  wire force_wr = wr_ext && reg_wdata[SSDP_FORCE_BIT];
  wire tx_accept = wr_data && tx_empty_q;
  wire fifo_rd = rd_data && cnt_q != '0;

  // frame length from code; prohibited codes fall back to eight
  logic [3:0] frame_len;
  always_comb begin
    case (ext_q.length_sel)
      3'h1: frame_len = 4'h5;
      3'h2: frame_len = 4'h6;
      3'h3: frame_len = 4'h7;
      3'h4: frame_len = 4'h9;
      default: frame_len = 4'h8;
    endcase
  end
  wire [8:0] len_mask = 9'(10'h3FF >> (4'hA - frame_len));

  // ----------------------------------------------------------------
  // serial clock edges
  // ----------------------------------------------------------------
  wire shifting = state_q == st_shift;
  wire tick = ctrl_q.master && shifting && div_q == HDIV_C - 4'h1;
  wire sck_rise = ctrl_q.master ? (tick && !sck_q) : (sck_s2_q && !sck_s3_q);
  wire sck_fall = ctrl_q.master ? (tick && sck_q) : (!sck_s2_q && sck_s3_q);
  wire last_bit = bit_q == frame_len - 4'h1;
  // receiver off: the frame is clocked through but not kept
  wire rx_done = shifting && sck_rise && last_bit && ctrl_q.rx_enable;
  wire [8:0] rx_word = rx_sh_q | (9'(sin_s2_q) << bit_q);
  wire [7:0] wait_len = 8'(ext_q.wait_sel) * 8'(HDIV_C) * 8'h2;
  wire have_tx = ctrl_q.tx_enable && !tx_empty_q;
  wire m_load = ctrl_q.master && state_q == st_idle && have_tx;
  wire s_start = !ctrl_q.master && state_q == st_idle && sck_fall &&
                 (ctrl_q.tx_enable || ctrl_q.rx_enable);
  wire load = m_load || (s_start && have_tx);
  wire [8:0] tx_word = tx_data_q & len_mask;

  // ----------------------------------------------------------------
  // receive store decisions
  // ----------------------------------------------------------------
  wire fifo_mode = ctrl_q.rx_fifo_en;
  wire store_ovr = rx_done && (fifo_mode ? cnt_q == DEPTH_C : rx_full_q);
  wire push = rx_done && fifo_mode && cnt_q != DEPTH_C;
  wire store_reg = rx_done && !fifo_mode && !rx_full_q;
  wire [PW:0] cnt_d = cnt_q + (PW + 1)'(push) - (PW + 1)'(fifo_rd);
  wire fifo_hit = push && cnt_d >= (PW + 1)'(ctrl_q.rx_thresh) + (PW + 1)'(1);
  wire [8:0] rd_word = ovr_q ? 9'h000 : (cnt_q != '0 ? fifo_mem[rd_ptr_q] : rx_data_q);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    sck_s1_q <= sck_in;
    sck_s2_q <= sck_s1_q;
    sck_s3_q <= sck_s2_q;
    sin_s1_q <= serial_input_pin;
    sin_s2_q <= sin_s1_q;
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= SSDP_CTRL_RST;
      ext_q <= SSDP_EXT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[7:0];
      end
      if (store_ovr && fifo_mode) begin
        ctrl_q.rx_fifo_en <= 1'b0;
      end
      if (wr_ext) begin
        ext_q <= reg_wdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= st_idle;
      div_q <= 4'h0;
      bit_q <= 4'h0;
      wait_q <= 8'h00;
      sck_q <= 1'b1;
      tx_sh_q <= SSDP_TX_RST;
      rx_sh_q <= SSDP_RX_RST;
    end else begin
      div_q <= (tick || !shifting) ? 4'h0 : div_q + 4'h1;
      if (tick) begin
        sck_q <= !sck_q;
      end
      case (state_q)
        st_idle: begin
          bit_q <= 4'h0;
          rx_sh_q <= SSDP_RX_RST;
          sck_q <= 1'b1;
          if (m_load) begin
            tx_sh_q <= tx_word;
            state_q <= st_shift;
          end else if (s_start) begin
            tx_sh_q <= have_tx ? tx_word >> 1 : SSDP_TX_RST;
            state_q <= st_shift;
          end
        end
        st_shift: begin
          if (sck_fall && ctrl_q.master) begin
            tx_sh_q <= tx_sh_q >> 1;
          end else if (sck_fall) begin
            tx_sh_q <= tx_sh_q >> 1;
          end
          if (sck_rise) begin
            rx_sh_q <= rx_word;
            bit_q <= bit_q + 4'h1;
            if (last_bit) begin
              wait_q <= 8'h00;
              state_q <= (ctrl_q.master && ext_q.wait_sel != 2'h0) ? st_wait : st_idle;
            end
          end
        end
        st_wait: begin
          wait_q <= wait_q + 8'h01;
          // a wait code cleared mid-gap ends the gap at once
          if (wait_q + 8'h01 >= wait_len) begin
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial output and clock pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_out_pin <= 1'b1;
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      sck_out <= ctrl_q.master ? sck_q : 1'b1;
      sck_oe <= ctrl_q.master;
      if (s_start) begin
        serial_out_pin <= have_tx ? tx_word[0] : 1'b1;
      end else if (shifting && sck_fall) begin
        serial_out_pin <= tx_sh_q[0];
      end else if (force_wr) begin
        serial_out_pin <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data_q <= SSDP_TX_RST;
      tx_empty_q <= 1'b1;
    end else begin
      if (tx_accept) begin
        tx_data_q <= reg_wdata[8:0];
        tx_empty_q <= 1'b0;
      end else if (load) begin
        tx_empty_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive buffer, fifo and overrun
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_data_q <= SSDP_RX_RST;
      rx_full_q <= 1'b0;
      ovr_q <= 1'b0;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (push) begin
        fifo_mem[wr_ptr_q] <= rx_word;
        wr_ptr_q <= wr_ptr_q + PW'(1);
      end
      if (fifo_rd) begin
        rd_ptr_q <= rd_ptr_q + PW'(1);
      end
      if (store_reg) begin
        rx_data_q <= rx_word;
      end
      // a new frame outranks a clearing read
      if (store_reg || fifo_hit) begin
        rx_full_q <= 1'b1;
      end else if (rd_data && cnt_q == '0) begin
        rx_full_q <= 1'b0;
      end else if (fifo_rd && cnt_d == '0) begin
        rx_full_q <= 1'b0;
      end
      if (store_ovr) begin
        ovr_q <= 1'b1;
      end else if (wr_ctrl && reg_wdata[SSDP_CLR_OVR_BIT]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port and requests
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      rx_irq <= ctrl_q.rx_irq_enable && (rx_full_q || ovr_q);
      tx_irq <= ctrl_q.tx_irq_enable && tx_empty_q;
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          SSDP_CTRL_OFS: reg_rdata <= {8'h00, ctrl_q};
          SSDP_EXT_OFS: reg_rdata <= {11'h000, ext_q};
          SSDP_STAT_OFS: reg_rdata <= {12'h000, state_q == st_idle && tx_empty_q,
                                       ovr_q, tx_empty_q, rx_full_q};
          SSDP_DATA_OFS: reg_rdata <= {7'h00, rd_word};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_force_drive: assert property (@(posedge sys_clk) disable iff (rst)
    force_wr && !shifting && !s_start |=> serial_out_pin)
    else $error("force write did not drive output high");
  chk_force_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == SSDP_EXT_OFS |=> !reg_rdata[SSDP_FORCE_BIT])
    else $error("force bit read back as one");
  chk_tx_write_clear: assert property (@(posedge sys_clk) disable iff (rst)
    tx_accept |=> !tx_empty_q && tx_data_q == $past(reg_wdata[8:0]))
    else $error("accepted write did not clear empty flag");
  chk_tx_refused: assert property (@(posedge sys_clk) disable iff (rst)
    wr_data && !tx_empty_q |=> $stable(tx_data_q))
    else $error("write accepted while buffer full");
  chk_tx_load_empty: assert property (@(posedge sys_clk) disable iff (rst)
    load |=> tx_empty_q ##1 (tx_irq || !$past(ctrl_q.tx_irq_enable)))
    else $error("load did not set empty flag and request");
  chk_rx_set_full: assert property (@(posedge sys_clk) disable iff (rst)
    store_reg |=> rx_full_q && (rx_data_q & ~$past(len_mask)) == 9'h000)
    else $error("frame store wrong or upper bits set");
  chk_rx_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
    rd_data && cnt_q == '0 && !store_reg && !fifo_hit |=> !rx_full_q)
    else $error("data read did not clear full flag");
  chk_ovr_invalid: assert property (@(posedge sys_clk) disable iff (rst)
    rd_data && ovr_q |=> reg_rdata == 16'h0000)
    else $error("data returned during overrun");
  chk_fifo_ovr_off: assert property (@(posedge sys_clk) disable iff (rst)
    store_ovr && fifo_mode && !wr_ctrl |=> !ctrl_q.rx_fifo_en && ovr_q && $stable(wr_ptr_q))
    else $error("fifo overrun did not disable fifo");
  chk_wait_gap: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state_q == st_wait) |-> $past(ext_q.wait_sel) != 2'h0 && sck_q)
    else $error("wait entered without wait code");
  chk_rx_irq_raise: assert property (@(posedge sys_clk) disable iff (rst)
    rx_full_q && ctrl_q.rx_irq_enable |=> rx_irq)
    else $error("full flag did not raise receive request");
  chk_fifo_set_full: assert property (@(posedge sys_clk) disable iff (rst)
    fifo_hit |=> rx_full_q)
    else $error("fifo count reached without full flag");
  chk_fifo_empty_clear: assert property (@(posedge sys_clk) disable iff (rst)
    fifo_rd && cnt_d == '0 && !store_reg && !fifo_hit |=> !rx_full_q)
    else $error("empty fifo left full flag set");
  chk_tx_upper_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    m_load |=> (tx_sh_q & ~$past(len_mask)) == 9'h000)
    else $error("bits above frame length reached shifter");
  chk_wait_hold: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == st_wait && wait_q + 8'h01 < wait_len |=> state_q == st_wait)
    else $error("wait gap ended early");
  chk_wait_exit: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == st_wait && wait_q + 8'h01 >= wait_len |=> state_q == st_idle)
    else $error("wait gap ran too long");
  chk_force_hold: assert property (@(posedge sys_clk) disable iff (rst)
    serial_out_pin && !shifting && !s_start |=> serial_out_pin)
    else $error("output left high level outside a frame");
  chk_tx_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_q.tx_irq_enable && tx_empty_q |=> tx_irq)
    else $error("empty flag did not raise transmit request");
endmodule
`default_nettype wire

/* dv/ssdp_peer.sv */
// Purpose: serial peer on the far side of the data path
// Assumes: clock idles high, data moves on falling, sampled on rising
// Notes: lsb first; makes its own clock only in slave bursts
`timescale 1ns/10ps
`default_nettype none
module ssdp_peer (
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_out_pin,
  input wire logic [8:0] peer_tx,
  input wire logic [3:0] peer_len,
  input wire logic peer_clr,
  output logic sck_in,
  output logic serial_input_pin,
  output logic [8:0] peer_rx,
  output int peer_cnt
);
  wire logic sck;
  logic [3:0] idx;
  assign sck = sck_oe ? sck_out : sck_in;
  initial begin
    sck_in = 1'b1;
    serial_input_pin = 1'b0;
    peer_rx = 9'h000;
    peer_cnt = 0;
    idx = 4'h0;
  end
  always @(posedge peer_clr) begin
    peer_cnt = 0;
    idx = 4'h0;
  end
  // next bit after each falling edge, frame length wraps the index
  always @(negedge sck) begin
    serial_input_pin <= peer_tx[idx];
    idx <= (idx + 4'h1 == peer_len) ? 4'h0 : idx + 4'h1;
  end
  // capture on rising; line flips once the frame is over
  always @(posedge sck) begin
    peer_rx <= {serial_out_pin, peer_rx[8:1]};
    peer_cnt <= peer_cnt + 1;
    if (idx == 4'h0) serial_input_pin <= #10 ~serial_input_pin;
  end
  // slave mode clock, idle high between bursts
  task automatic burst(input int n);
    repeat (n) begin
      #32 sck_in = 1'b0;
      #32 sck_in = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* dv/ssdp_core_tb.sv */
// Purpose: self-checking bench of the serial data path
// Assumes: peer model on the serial side
// Notes: half period 4 cycles, lsb first
`timescale 1ns/10ps
`default_nettype none
module ssdp_core_tb;
  import ssdp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, s;
  logic sck_in, sck_out, sck_oe, serial_input_pin, serial_out_pin, rx_irq, tx_irq;
  logic [8:0] peer_tx = 9'h0D3;
  logic [8:0] peer_rx, m;
  logic [3:0] peer_len = 4'h8;
  logic peer_clr = 1'b0;
  int peer_cnt, failures = 0, samples_checked = 0, cyc = 0, hi = 0, gap = 0, g0 = 0;
  int lens [5] = '{8, 5, 6, 7, 9};
  always #2.5 sys_clk = ~sys_clk;
  ssdp_core #(.HALF_DIV(4), .FIFO_DEPTH(4)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .serial_input_pin(serial_input_pin), .serial_out_pin(serial_out_pin),
    .rx_irq(rx_irq), .tx_irq(tx_irq));
  ssdp_peer u_peer (.sck_out(sck_out), .sck_oe(sck_oe), .serial_out_pin(serial_out_pin),
    .peer_tx(peer_tx), .peer_len(peer_len), .peer_clr(peer_clr), .sck_in(sck_in),
    .serial_input_pin(serial_input_pin), .peer_rx(peer_rx), .peer_cnt(peer_cnt));
  // longest high stretch of the serial clock between frames
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (sck_out) hi <= hi + 1;
    else begin
      if (hi > gap) gap <= hi;
      hi <= 0;
    end
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 300; i++) begin
      rd(SSDP_STAT_OFS, s);
      if (s[b] === v) break;
    end
  endtask
  task automatic clr();
    peer_clr <= 1'b1;
    @(posedge sys_clk);
    peer_clr <= 1'b0;
  endtask
  task automatic waitc(input int n);
    for (int i = 0; i < 3000 && peer_cnt < n; i++) @(posedge sys_clk);
    repeat (12) @(posedge sys_clk);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc("ctrl", SSDP_CTRL_OFS, 16'h0000);
    rdc("ext", SSDP_EXT_OFS, 16'h0000);
    rdc("stat", SSDP_STAT_OFS, 16'h000A);
    rdc("unmapped", 4'h2, 16'h0000);
    $display("reset test done");
    for (int c = 0; c < 5; c++) begin
      peer_len <= lens[c][3:0];
      m = 9'h1FF >> (9 - lens[c]);
      clr();
      wr(SSDP_EXT_OFS, 16'(c));
      wr(SSDP_CTRL_OFS, 16'h001F);
      wr(SSDP_DATA_OFS, 16'h01A5);
      poll(SSDP_ST_FULL, 1'b1);
      @(negedge sys_clk);
      chk("tx frame", {7'h00, 9'h1A5 & m}, {7'h00, peer_rx >> (9 - lens[c])});
      chk("rx irq", 16'h0001, {15'h0000, rx_irq});
      chk("tx irq", 16'h0001, {15'h0000, tx_irq});
      @(posedge sys_clk);
      rdc("rx data", SSDP_DATA_OFS, {7'h00, 9'h0D3 & m});
      rdc("stat", SSDP_STAT_OFS, 16'h000A);
    end
    $display("length test done");
    peer_len <= 4'h8;
    wr(SSDP_EXT_OFS, 16'h0000);
    wr(SSDP_DATA_OFS, 16'h0011);
    poll(SSDP_ST_FULL, 1'b1);
    wr(SSDP_DATA_OFS, 16'h0022);
    poll(SSDP_ST_OVR, 1'b1);
    rdc("stat ovr", SSDP_STAT_OFS, 16'h000F);
    rdc("ovr data", SSDP_DATA_OFS, 16'h0000);
    wr(SSDP_CTRL_OFS, 16'h011F);
    rdc("stat", SSDP_STAT_OFS, 16'h000A);
    wr(SSDP_DATA_OFS, 16'h0033);
    poll(SSDP_ST_FULL, 1'b1);
    rdc("rx data", SSDP_DATA_OFS, 16'h00D3);
    $display("overrun test done");
    wr(SSDP_CTRL_OFS, 16'h0067);
    for (int i = 1; i < 6; i++) begin
      clr();
      wr(SSDP_DATA_OFS, 16'(i));
      waitc(8);
      rd(SSDP_STAT_OFS, s);
      if (i < 3) chk("fifo full", (i == 2) ? 16'h0001 : 16'h0000, s & 16'h0001);
    end
    rdc("stat ovr", SSDP_STAT_OFS, 16'h000F);
    rdc("ctrl", SSDP_CTRL_OFS, 16'h0047);
    wr(SSDP_CTRL_OFS, 16'h0147);
    for (int i = 0; i < 4; i++) rdc("fifo data", SSDP_DATA_OFS, 16'h00D3);
    $display("fifo test done");
    for (int w = 0; w < 4; w++) begin
      wr(SSDP_EXT_OFS, 16'(w << 3));
      wr(SSDP_CTRL_OFS, 16'h0005);
      clr();
      wr(SSDP_DATA_OFS, 16'h00F0);
      poll(SSDP_ST_EMPTY, 1'b1);
      wr(SSDP_DATA_OFS, 16'h0055);
      rdc("stat busy", SSDP_STAT_OFS, 16'h0000);
      wr(SSDP_DATA_OFS, 16'h00FF);
      waitc(2);
      gap = 0;
      waitc(16);
      chk("second frame", 16'h0055, {8'h00, peer_rx[8:1]});
      if (w == 0) g0 = gap;
      chk("gap", g0 + 8 * w, gap);
    end
    $display("wait test done");
    wr(SSDP_EXT_OFS, 16'h0098);
    rdc("ext", SSDP_EXT_OFS, 16'h0018);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("forced pin", 16'h0001, {15'h0000, serial_out_pin});
    @(posedge sys_clk);
    clr();
    wr(SSDP_DATA_OFS, 16'h0000);
    waitc(3);
    @(negedge sys_clk);
    chk("pin in frame", 16'h0000, {15'h0000, serial_out_pin});
    $display("force test done");
    waitc(8);
    wr(SSDP_CTRL_OFS, 16'h0003);
    wr(SSDP_EXT_OFS, 16'h0000);
    clr();
    wr(SSDP_DATA_OFS, 16'h003C);
    u_peer.burst(8);
    repeat (20) @(posedge sys_clk);
    chk("slave tx", 16'h003C, {8'h00, peer_rx[8:1]});
    chk("slave clk", 16'h0000, {15'h0000, sck_oe});
    rdc("slave rx", SSDP_DATA_OFS, 16'h00D3);
    $display("slave test done");
    results();
  end
endmodule
`default_nettype wire
